// ---- src/lewt_timer.sv ----
// Top of the low-energy wakeup timer: APB register file, flags, interrupt, wake request.
// Assumes an APB master on mclk_in and a timer clock tick synchronous to the same clock.
//
// Notes on behaviour
// - Interval exponent is bits 5:0, read/write, reset 0x20.
// - Exponent n, 0 to 32, gives one wakeup event every 2^n prescaled cycles.
// - Exponent 32 gives one event per full 32-bit counter cycle.
// - Full 32-bit running count readable, read-only, resets to zero.
// - Hibernate wake enable bit lets events request wake; resets to zero.
// - Writing one to flag set register sets the periodic flag.
// - Writing one to flag clear register clears the periodic flag.
// - With read-clear enabled, reading flag clear returns and clears flags.
// - Timer held in reset until enable set; clearing enable resets it.
// - Events set the flag; interrupt while flag and enable both set.
// - Prescale select divides timer clock by 2^value, 0 to 7.
// - Reflex pulse lasts one timer clock; shorter when both selects are zero.
`timescale 1ns/1ps
`default_nettype none
module lewt_timer
	import lewt_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer clock tick and system option
	input wire logic timer_tick_in,
	input wire logic read_clear_en_in,
	// Event outputs
	output logic irq_out,
	output logic hibernate_wake_req_out,
	output logic peripheral_reflex_out
);

	logic ctrl_en_r;
	logic ctrl_en_nxt;
	logic [2:0] prescale_select_r;
	logic [2:0] prescale_select_nxt;
	logic [5:0] exp_r;
	logic [5:0] exp_nxt;
	logic hib_en_r;
	logic hib_en_nxt;
	logic flag_r;
	logic flag_nxt;
	logic irq_en_r;
	logic irq_en_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic wake_r;
	logic wake_nxt;
	logic wr_acc;
	logic rd_acc;
	lewt_cfg_s cfg;
	lewt_stat_s stat;

	// Word match on the byte address
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return (a[11:2] == ofs[11:2]);
	endfunction

	// Counting core
	lewt_core u_core (
		.mclk_in(mclk_in),
		.sys_rst_in(sys_rst_in),
		.timer_tick_in(timer_tick_in),
		.cfg_in(cfg),
		.stat_out(stat)
	);

	assign cfg = '{
		enable: ctrl_en_r,
		prescale_select: prescale_select_r,
		interval_exponent: exp_r
	};

	// Zero wait states, so every access completes in its first access cycle
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Register file next state; reserved bits are simply dropped
	always_comb begin
		ctrl_en_nxt = ctrl_en_r;
		prescale_select_nxt = prescale_select_r;
		exp_nxt = exp_r;
		hib_en_nxt = hib_en_r;
		flag_nxt = flag_r;
		irq_en_nxt = irq_en_r;
		if (wr_acc) begin
			if (hit(paddr, LEWT_CTRL_OFS)) begin
				ctrl_en_nxt = pwdata[LEWT_CTRL_EN_BIT];
				prescale_select_nxt = pwdata[LEWT_PRESCALE_SELECT_LSB +: LEWT_PRESCALE_SELECT_W];
			end
			if (hit(paddr, LEWT_INTERVAL_OFS))
				exp_nxt = pwdata[LEWT_EXP_W-1:0];
			if (hit(paddr, LEWT_HIBWAKE_OFS))
				hib_en_nxt = pwdata[0];
			if (hit(paddr, LEWT_IRQ_EN_OFS))
				irq_en_nxt = pwdata[LEWT_PERIOD_BIT];
			if (hit(paddr, LEWT_FLAGS_CLR_OFS) && pwdata[LEWT_PERIOD_BIT])
				flag_nxt = 1'b0;
			if (hit(paddr, LEWT_FLAGS_SET_OFS) && pwdata[LEWT_PERIOD_BIT])
				flag_nxt = 1'b1;
		end
		// Read-clear of the flag clear register
		if (rd_acc && read_clear_en_in && hit(paddr, LEWT_FLAGS_CLR_OFS))
			flag_nxt = 1'b0;
		// A hardware event wins over any clear in the same cycle
		if (stat.wake_event)
			flag_nxt = 1'b1;
	end

	// Read data mux, sampled in the setup cycle so it is stable in the access phase
	always_comb begin
		prdata_nxt = LEWT_RDATA_NONE;
		if (psel && !penable && !pwrite) begin
			case (paddr[11:2])
				LEWT_CTRL_OFS[11:2]: begin
					prdata_nxt[LEWT_CTRL_EN_BIT] = ctrl_en_r;
					prdata_nxt[LEWT_PRESCALE_SELECT_LSB +: LEWT_PRESCALE_SELECT_W] = prescale_select_r;
				end
				LEWT_INTERVAL_OFS[11:2]: prdata_nxt[LEWT_EXP_W-1:0] = exp_r;
				LEWT_COUNT_OFS[11:2]: prdata_nxt = stat.running_count;
				LEWT_HIBWAKE_OFS[11:2]: prdata_nxt[0] = hib_en_r;
				LEWT_FLAGS_OFS[11:2]: prdata_nxt[LEWT_PERIOD_BIT] = flag_r;
				LEWT_FLAGS_CLR_OFS[11:2]: begin
					if (read_clear_en_in)
						prdata_nxt[LEWT_PERIOD_BIT] = flag_r;
				end
				LEWT_IRQ_EN_OFS[11:2]: prdata_nxt[LEWT_PERIOD_BIT] = irq_en_r;
				default: prdata_nxt = LEWT_RDATA_NONE;
			endcase
		end else begin
			prdata_nxt = prdata_r;
		end
	end

	// Wake request follows each event while hibernate wake is enabled
	always_comb begin
		wake_nxt = stat.wake_event & hib_en_r;
	end

	// Registers only
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			ctrl_en_r <= 1'b0;
			prescale_select_r <= 3'h0;
			exp_r <= LEWT_EXP_RESET;
			hib_en_r <= 1'b0;
			flag_r <= 1'b0;
			irq_en_r <= 1'b0;
			prdata_r <= LEWT_RDATA_NONE;
			wake_r <= 1'b0;
		end else begin
			ctrl_en_r <= ctrl_en_nxt;
			prescale_select_r <= prescale_select_nxt;
			exp_r <= exp_nxt;
			hib_en_r <= hib_en_nxt;
			flag_r <= flag_nxt;
			irq_en_r <= irq_en_nxt;
			prdata_r <= prdata_nxt;
			wake_r <= wake_nxt;
		end
	end

	// Outputs
	assign prdata = prdata_r;
	assign irq_out = flag_r & irq_en_r;
	assign hibernate_wake_req_out = wake_r;
	assign peripheral_reflex_out = stat.reflex_pulse;

	// Interval exponent resets to its documented value
	property p_exp_reset;
		@(posedge mclk_in) sys_rst_in |=> (exp_r == LEWT_EXP_RESET);
	endproperty
	a_exp_reset: assert property (p_exp_reset) else $error("exponent reset wrong");

	// Count register read returns the counter
	property p_count_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(psel && !penable && !pwrite && paddr == LEWT_COUNT_OFS) |=>
			(prdata == $past(stat.running_count));
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	// Wake request only with hibernate enable and an event
	property p_wake;
		@(posedge mclk_in) disable iff (sys_rst_in)
		hibernate_wake_req_out |-> ($past(hib_en_r) && $past(stat.wake_event));
	endproperty
	a_wake: assert property (p_wake) else $error("spurious wake request");

	// Set register raises the flag
	property p_flag_set;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && paddr == LEWT_FLAGS_SET_OFS && pwdata[0]) |=> flag_r;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	// Clear register drops the flag unless an event coincides
	property p_flag_clr;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && paddr == LEWT_FLAGS_CLR_OFS && pwdata[0] && !stat.wake_event) |=> !flag_r;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

	// Read-clear empties the flag
	property p_read_clear;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(rd_acc && read_clear_en_in && paddr == LEWT_FLAGS_CLR_OFS && !stat.wake_event)
			|=> !flag_r;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read-clear failed");

	// Event sets the flag and interrupt follows flag and enable
	property p_event_flag;
		@(posedge mclk_in) disable iff (sys_rst_in)
		stat.wake_event |=> (flag_r && (irq_out == irq_en_r));
	endproperty
	a_event_flag: assert property (p_event_flag) else $error("event lost");

	// Disabled timer holds counter at zero one cycle later
	property p_disable_reset;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(!ctrl_en_r) |=> (stat.running_count == 32'h0000_0000);
	endproperty
	a_disable_reset: assert property (p_disable_reset) else $error("not held in reset");

	// Control write lands at the access edge
	property p_ctrl_write;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && hit(paddr, LEWT_CTRL_OFS)) |=>
			(ctrl_en_r == $past(pwdata[LEWT_CTRL_EN_BIT]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("enable not written");

	// Prescale select is taken from the control write
	property p_prescale_select_write;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && hit(paddr, LEWT_CTRL_OFS)) |=>
			(prescale_select_r == $past(pwdata[LEWT_PRESCALE_SELECT_LSB +: LEWT_PRESCALE_SELECT_W]));
	endproperty
	a_prescale_select_write: assert property (p_prescale_select_write) else $error("prescale not written");

	// Interval exponent is taken from its write
	property p_interval_write;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && hit(paddr, LEWT_INTERVAL_OFS)) |=>
			(exp_r == $past(pwdata[LEWT_EXP_W-1:0]));
	endproperty
	a_interval_write: assert property (p_interval_write) else $error("exponent not written");

	// Hibernate wake enable follows its write, one and zero alike
	property p_hib_write;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && hit(paddr, LEWT_HIBWAKE_OFS)) |=>
			(hib_en_r == $past(pwdata[0]));
	endproperty
	a_hib_write: assert property (p_hib_write) else $error("wake enable not written");

	// Interrupt enable follows its write
	property p_irq_en_write;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(wr_acc && hit(paddr, LEWT_IRQ_EN_OFS)) |=>
			(irq_en_r == $past(pwdata[LEWT_PERIOD_BIT]));
	endproperty
	a_irq_en_write: assert property (p_irq_en_write) else $error("irq enable not written");

	// Each event with hibernate wake enabled raises the wake request
	property p_wake_follows;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(stat.wake_event && hib_en_r) |=> hibernate_wake_req_out;
	endproperty
	a_wake_follows: assert property (p_wake_follows) else $error("wake request lost");

	// Clearing the enable withdraws the wake request
	property p_wake_withdrawn;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(!hib_en_r) |=> !hibernate_wake_req_out;
	endproperty
	a_wake_withdrawn: assert property (p_wake_withdrawn) else $error("wake not withdrawn");

	// Flag moves only for an event, a set, a clear or a read-clear
	property p_flag_quiet;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(!stat.wake_event && !(wr_acc && hit(paddr, LEWT_FLAGS_SET_OFS)) &&
			!(psel && penable && hit(paddr, LEWT_FLAGS_CLR_OFS))) |=> $stable(flag_r);
	endproperty
	a_flag_quiet: assert property (p_flag_quiet) else $error("flag moved");

	// Without the read-clear option a read of the clear register keeps the flag
	property p_rc_off;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(rd_acc && !read_clear_en_in && hit(paddr, LEWT_FLAGS_CLR_OFS) && flag_r) |=>
			flag_r;
	endproperty
	a_rc_off: assert property (p_rc_off) else $error("flag lost on plain read");

	// Every event shows on the reflex output
	property p_reflex_event;
		@(posedge mclk_in) disable iff (sys_rst_in)
		stat.wake_event |-> peripheral_reflex_out;
	endproperty
	a_reflex_event: assert property (p_reflex_event) else $error("reflex pulse missing");

	// Control read shows enable and prescale in their fields
	property p_ctrl_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(psel && !penable && !pwrite && hit(paddr, LEWT_CTRL_OFS)) |=>
			(prdata == {24'h00_0000, $past(prescale_select_r), 4'h0, $past(ctrl_en_r)});
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

	// Interval read returns the exponent
	property p_interval_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(psel && !penable && !pwrite && hit(paddr, LEWT_INTERVAL_OFS)) |=>
			(prdata == {26'h000_0000, $past(exp_r)});
	endproperty
	a_interval_read: assert property (p_interval_read) else $error("exponent read wrong");

	// Flag register read returns the periodic flag
	property p_flags_read;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(psel && !penable && !pwrite && hit(paddr, LEWT_FLAGS_OFS)) |=>
			(prdata == {31'h0000_0000, $past(flag_r)});
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flag read wrong");

	c_event: cover property (@(posedge mclk_in) disable iff (sys_rst_in) stat.wake_event);
	c_irq: cover property (@(posedge mclk_in) disable iff (sys_rst_in) $rose(irq_out));
	c_wake: cover property (@(posedge mclk_in) disable iff (sys_rst_in) hibernate_wake_req_out);
	c_rdclr: cover property (@(posedge mclk_in) disable iff (sys_rst_in)
		rd_acc && read_clear_en_in && paddr == LEWT_FLAGS_CLR_OFS && flag_r);

endmodule : lewt_timer
`default_nettype wire

// ---- pkg/lewt_pkg.sv ----
// Package for the low-energy wakeup timer: register map, field layout, reset values
// and the structs that carry control and status between the register file and the core.
// Assumes a 32-bit APB register bus, byte addressed with one aligned word per register.
package lewt_pkg;

	// Register byte offsets
	localparam logic [11:0] LEWT_CTRL_OFS = 12'h000;
	localparam logic [11:0] LEWT_INTERVAL_OFS = 12'h004;
	localparam logic [11:0] LEWT_COUNT_OFS = 12'h008;
	localparam logic [11:0] LEWT_HIBWAKE_OFS = 12'h00C;
	localparam logic [11:0] LEWT_FLAGS_OFS = 12'h010;
	localparam logic [11:0] LEWT_FLAGS_SET_OFS = 12'h014;
	localparam logic [11:0] LEWT_FLAGS_CLR_OFS = 12'h018;
	localparam logic [11:0] LEWT_IRQ_EN_OFS = 12'h01C;

	// Control register fields
	localparam int LEWT_CTRL_EN_BIT = 0;
	localparam int LEWT_PRESCALE_SELECT_LSB = 5;
	localparam int LEWT_PRESCALE_SELECT_W = 3;

	// Interval exponent field
	localparam int LEWT_EXP_W = 6;
	localparam logic [5:0] LEWT_EXP_RESET = 6'h20;
	localparam logic [5:0] LEWT_EXP_MAX = 6'h20;

	// Flag bit of the periodic event
	localparam int LEWT_PERIOD_BIT = 0;

	// Counter width and reset
	localparam int LEWT_CNT_W = 32;
	localparam logic [31:0] LEWT_CNT_RESET = 32'h0000_0000;

	// Answer to an unmapped read
	localparam logic [31:0] LEWT_RDATA_NONE = 32'h0000_0000;

	// Configuration handed to the counting core
	typedef struct packed {
		logic enable;
		logic [2:0] prescale_select;
		logic [5:0] interval_exponent;
	} lewt_cfg_s;

	// State reported by the counting core
	typedef struct packed {
		logic [31:0] running_count;
		logic wake_event;
		logic reflex_pulse;
	} lewt_stat_s;

endpackage : lewt_pkg

// ---- src/lewt_core.sv ----
// Counting core of the low-energy wakeup timer: prescaler, 32-bit counter and event.
// Assumes the timer clock arrives as a one-cycle tick enable synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none
module lewt_core
	import lewt_pkg::*;
(
	// Clock and reset
	input wire logic mclk_in,
	input wire logic sys_rst_in,
	// Timer clock tick and configuration
	input wire logic timer_tick_in,
	input wire lewt_cfg_s cfg_in,
	// State out
	output lewt_stat_s stat_out
);

	logic [6:0] prescale_select_cnt_r;
	logic [6:0] prescale_select_cnt_nxt;
	logic [31:0] count_r;
	logic [31:0] count_nxt;
	logic event_r;
	logic event_nxt;
	logic pulse_r;
	logic pulse_nxt;
	logic prescale_select_tick;
	logic [31:0] low_mask;
	logic fast_mode;

	// Mask of the low exponent bits; 32 or more covers the whole counter
	function automatic logic [31:0] exp_mask(input logic [5:0] e);
		logic [31:0] m;
		m = 32'h0000_0000;
		if (e >= LEWT_EXP_MAX)
			m = 32'hFFFF_FFFF;
		else
			m = (32'h0000_0001 << e[4:0]) - 32'h0000_0001;
		return m;
	endfunction

	// Prescaled tick and counter next state
	always_comb begin
		prescale_select_cnt_nxt = prescale_select_cnt_r;
		count_nxt = count_r;
		event_nxt = 1'b0;
		fast_mode = (cfg_in.prescale_select == 3'h0) && (cfg_in.interval_exponent == 6'h00);
		// With both selects at zero the pulse drops after one system clock, so that
		// back-to-back events stay distinct edges; with a half-rate tick that is half a period
		pulse_nxt = pulse_r & ~timer_tick_in & ~fast_mode;
		low_mask = exp_mask(cfg_in.interval_exponent);
		prescale_select_tick = 1'b0;
		if (!cfg_in.enable) begin
			// Disabled means held in reset, so a restart counts from zero
			prescale_select_cnt_nxt = 7'h00;
			count_nxt = LEWT_CNT_RESET;
			pulse_nxt = 1'b0;
		end else if (timer_tick_in) begin
			// Divide by two to the prescale select
			prescale_select_tick = ((prescale_select_cnt_r & ((7'h01 << cfg_in.prescale_select) - 7'h01)) ==
				((7'h01 << cfg_in.prescale_select) - 7'h01));
			prescale_select_cnt_nxt = prescale_select_cnt_r + 7'h01;
			if (prescale_select_tick) begin
				count_nxt = count_r + 32'h0000_0001;
				// Event when the low exponent bits roll over to zero
				if ((count_nxt & low_mask) == 32'h0000_0000) begin
					event_nxt = 1'b1;
					pulse_nxt = 1'b1;
				end
			end
		end
	end

	// Registers only; pulse lasts until the next timer tick, or one system clock when both selects are zero
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			prescale_select_cnt_r <= 7'h00;
			count_r <= LEWT_CNT_RESET;
			event_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			prescale_select_cnt_r <= prescale_select_cnt_nxt;
			count_r <= count_nxt;
			event_r <= event_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign stat_out = '{running_count: count_r, wake_event: event_r, reflex_pulse: pulse_r};

	// Counter stays at zero while disabled
	property p_held_disabled;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(!cfg_in.enable) |=> (count_r == 32'h0000_0000);
	endproperty
	a_held_disabled: assert property (p_held_disabled) else $error("counter not held");

	// Counter moves by at most one
	property p_step_one;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(cfg_in.enable && $past(cfg_in.enable)) |->
			(count_r == $past(count_r) || count_r == $past(count_r) + 32'h0000_0001);
	endproperty
	a_step_one: assert property (p_step_one) else $error("counter jumped");

	// No count without a timer tick
	property p_no_tick_no_count;
		@(posedge mclk_in) disable iff (sys_rst_in)
		(cfg_in.enable && !timer_tick_in) |=> $stable(count_r);
	endproperty
	a_no_tick_no_count: assert property (p_no_tick_no_count) else $error("count w/o tick");

	// Event only with low bits of counter at zero
	property p_event_aligned;
		@(posedge mclk_in) disable iff (sys_rst_in)
		event_r |-> ((count_r & exp_mask(cfg_in.interval_exponent)) == 32'h0000_0000);
	endproperty
	a_event_aligned: assert property (p_event_aligned) else $error("event misaligned");

endmodule : lewt_core
`default_nettype wire

// ---- verification/lewt_timer_tb.sv ----
// Self-checking bench for the wakeup timer top: registers, flags, interrupt and counting.
// Assumes the APB slave answers in its first access cycle and one clock domain throughout.
`timescale 1ns/1ps
`default_nettype none
module lewt_timer_tb
	import lewt_pkg::*;
;
	logic mclk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer_tick_in = 1'b0;
	logic read_clear_en_in = 1'b0;
	logic irq_out;
	logic hibernate_wake_req_out;
	logic peripheral_reflex_out;
	logic reflex_q = 1'b0;
	logic [31:0] rd;
	int bad_count = 0;
	int check_count = 0;
	int wake_cnt = 0;
	int reflex_cnt = 0;

	// Free-running 250 MHz clock
	always #2 mclk_in = ~mclk_in;

	lewt_timer DUT (
		.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_tick_in(timer_tick_in), .read_clear_en_in(read_clear_en_in),
		.irq_out(irq_out), .hibernate_wake_req_out(hibernate_wake_req_out),
		.peripheral_reflex_out(peripheral_reflex_out)
	);

	// Tally wake pulses and reflex rising edges; scenarios compare deltas
	always @(posedge mclk_in) begin
		reflex_q <= peripheral_reflex_out;
		if (hibernate_wake_req_out === 1'b1) wake_cnt <= wake_cnt + 1;
		if (peripheral_reflex_out === 1'b1 && reflex_q !== 1'b1) reflex_cnt <= reflex_cnt + 1;
	end

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge mclk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", 32'(pslverr), 32'h0000_0000);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk_in);
	endtask

	task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, e);
	endtask

	// Timer ticks every other cycle, then a short settle for the event pipeline
	task ticks(input int n);
		repeat (n) begin
			timer_tick_in <= 1'b1;
			@(posedge mclk_in);
			timer_tick_in <= 1'b0;
			@(posedge mclk_in);
		end
		repeat (4) @(posedge mclk_in);
	endtask

	task t_reset();
		rchk("interval", LEWT_INTERVAL_OFS, 32'h0000_0020);
		rchk("count", LEWT_COUNT_OFS, 32'h0000_0000);
		rchk("hibwake", LEWT_HIBWAKE_OFS, 32'h0000_0000);
		rchk("flags", LEWT_FLAGS_OFS, 32'h0000_0000);
		rchk("irq_en", LEWT_IRQ_EN_OFS, 32'h0000_0000);
		rchk("ctrl", LEWT_CTRL_OFS, 32'h0000_0000);
		rchk("unmapped", 12'h020, 32'h0000_0000);
	endtask

	task t_regs();
		apb(1'b1, LEWT_INTERVAL_OFS, 32'h0000_0015);
		rchk("interval rw", LEWT_INTERVAL_OFS, 32'h0000_0015);
		apb(1'b1, LEWT_COUNT_OFS, 32'hFFFF_FFFF);
		rchk("count ro", LEWT_COUNT_OFS, 32'h0000_0000);
		apb(1'b1, LEWT_HIBWAKE_OFS, 32'h0000_0001);
		rchk("hibwake rw", LEWT_HIBWAKE_OFS, 32'h0000_0001);
	endtask

	task t_flags();
		apb(1'b1, LEWT_FLAGS_SET_OFS, 32'h0000_0000);
		rchk("set zero", LEWT_FLAGS_OFS, 32'h0000_0000);
		apb(1'b1, LEWT_FLAGS_SET_OFS, 32'h0000_0001);
		rchk("set one", LEWT_FLAGS_OFS, 32'h0000_0001);
		chk("irq masked", irq_out, 32'h0000_0000);
		apb(1'b1, LEWT_IRQ_EN_OFS, 32'h0000_0001);
		chk("irq on", irq_out, 32'h0000_0001);
		apb(1'b1, LEWT_FLAGS_CLR_OFS, 32'h0000_0000);
		rchk("clr zero", LEWT_FLAGS_OFS, 32'h0000_0001);
		apb(1'b1, LEWT_FLAGS_CLR_OFS, 32'h0000_0001);
		rchk("clr one", LEWT_FLAGS_OFS, 32'h0000_0000);
		chk("irq off", irq_out, 32'h0000_0000);
		apb(1'b1, LEWT_FLAGS_SET_OFS, 32'h0000_0001);
		rchk("rc off", LEWT_FLAGS_CLR_OFS, 32'h0000_0000);
		rchk("rc kept", LEWT_FLAGS_OFS, 32'h0000_0001);
		read_clear_en_in <= 1'b1;
		rchk("read clear", LEWT_FLAGS_CLR_OFS, 32'h0000_0001);
		rchk("after rc", LEWT_FLAGS_OFS, 32'h0000_0000);
		read_clear_en_in <= 1'b0;
	endtask

	// Prescale and exponent table; exponent 32 never fires in a short run
	task t_count();
		int pr[5] = '{0, 1, 2, 7, 0};
		int ex[5] = '{0, 2, 1, 0, 32};
		int tk[5] = '{5, 20, 12, 256, 6};
		int c;
		int ev;
		int w0;
		int r0;
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, LEWT_INTERVAL_OFS, 32'(ex[i]));
			apb(1'b1, LEWT_CTRL_OFS, 32'((pr[i] << LEWT_PRESCALE_SELECT_LSB) | 1));
			rchk("ctrl", LEWT_CTRL_OFS, 32'((pr[i] << LEWT_PRESCALE_SELECT_LSB) | 1));
			w0 = wake_cnt;
			r0 = reflex_cnt;
			ticks(tk[i]);
			c = tk[i] >> pr[i];
			ev = (ex[i] >= 32) ? 0 : (c >> ex[i]);
			rchk("count", LEWT_COUNT_OFS, 32'(c));
			chk("wakes", 32'(wake_cnt - w0), 32'(ev));
			chk("reflex", 32'(reflex_cnt - r0), 32'(ev));
			rchk("flag", LEWT_FLAGS_OFS, 32'(ev != 0));
			chk("irq", irq_out, 32'(ev != 0));
			apb(1'b1, LEWT_CTRL_OFS, 32'h0000_0000);
			rchk("stopped", LEWT_COUNT_OFS, 32'h0000_0000);
			apb(1'b1, LEWT_FLAGS_CLR_OFS, 32'h0000_0001);
		end
		apb(1'b1, LEWT_HIBWAKE_OFS, 32'h0000_0000);
		apb(1'b1, LEWT_INTERVAL_OFS, 32'h0000_0000);
		apb(1'b1, LEWT_CTRL_OFS, 32'h0000_0001);
		w0 = wake_cnt;
		ticks(3);
		chk("no wake", 32'(wake_cnt - w0), 32'h0000_0000);
		rchk("flag only", LEWT_FLAGS_OFS, 32'h0000_0001);
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence after a five-cycle reset
	initial begin
		repeat (5) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		@(posedge mclk_in);
		t_reset();
		t_regs();
		t_flags();
		t_count();
		summarize();
	end

	// Watchdog: the run needs about 850 cycles, so 10000 means a hang
	initial begin
		#40000;
		bad_count++;
		summarize();
	end
endmodule // lewt_timer_tb
`default_nettype wire
